// ---- pkg/rxcs_pkg.sv ----
// Shared constants for the receive control-six register bank
`default_nettype none

package rxcs_pkg;

  // Bus widths
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int PAD_W = DATA_W - REG_W;
  localparam int IDX_W = ADDR_W - 2;

  // Register indexes; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CTRL_A = 10'h01E;
  localparam logic [IDX_W-1:0] IDX_CTRL_B = 10'h0BE;
  localparam logic [IDX_W-1:0] IDX_MON_A = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_MON_B = 10'h0F1;

  // Field layout of the control register and width of the monitor slot
  localparam int CRC6_SEL_BIT = 7;
  localparam int ACCUM_SRC_BIT = 6;
  localparam int MAN_LATCH_BIT = 5;
  localparam int CHAN_MSB = 4;
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = CHAN_MSB - CHAN_LSB + 1;
  localparam int SLOT_W = 8;

  // Reset values
  localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [SLOT_W-1:0] MON_RESET = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

  // Timing: settle time before counters may be read
  localparam int CLK_PERIOD_NS = 10;
  localparam int LATCH_SETTLE_NS = 972;
  localparam int LATCH_SETTLE_CYC = (LATCH_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [IDX_W-1:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

endpackage : rxcs_pkg

`default_nettype wire

// ---- rtl/rxcs_framer_ctrl.sv ----
// One framer's receive control register, manual latch and channel monitor
`timescale 1ns/10ps
`default_nettype none

module rxcs_framer_ctrl #(
  parameter int SLOT_W = rxcs_pkg::SLOT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Register write
  input wire logic wr_en,
  input wire logic [rxcs_pkg::REG_W-1:0] wdata,
  // Framer side
  input wire logic timed_tick,
  input wire logic [rxcs_pkg::CHAN_W-1:0] slot_num,
  input wire logic [SLOT_W-1:0] slot_data,
  input wire logic slot_valid,
  // Outputs
  output logic [rxcs_pkg::REG_W-1:0] ctrl_reg,
  output logic crc6_sel,
  output logic [rxcs_pkg::CHAN_W-1:0] chan_sel,
  output logic latch_reg,
  output logic [SLOT_W-1:0] mon_reg
);

  logic man_prev_reg;
  wire [rxcs_pkg::REG_W-1:0] ctrl_next;
  wire latch_next;
  wire [SLOT_W-1:0] mon_next;
  wire man_mode;
  wire man_bit;
  wire man_rise;
  wire chan_hit;

  assign ctrl_next = wr_en ? wdata : ctrl_reg;
  assign crc6_sel = ctrl_reg[rxcs_pkg::CRC6_SEL_BIT];
  assign chan_sel = ctrl_reg[rxcs_pkg::CHAN_MSB:rxcs_pkg::CHAN_LSB];
  assign man_mode = ctrl_reg[rxcs_pkg::ACCUM_SRC_BIT];
  assign man_bit = ctrl_reg[rxcs_pkg::MAN_LATCH_BIT];
  // Edge tracked in both modes, so a bit left high before manual mode never fires
  assign man_rise = man_mode & man_bit & ~man_prev_reg;
  assign latch_next = man_mode ? man_rise : timed_tick;
  assign chan_hit = slot_valid && (slot_num == chan_sel);
  assign mon_next = chan_hit ? slot_data : mon_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= rxcs_pkg::CTRL_RESET;
      man_prev_reg <= 1'b0;
      latch_reg <= 1'b0;
      mon_reg <= rxcs_pkg::MON_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      man_prev_reg <= man_bit;
      latch_reg <= latch_next;
      mon_reg <= mon_next;
    end
  end

endmodule : rxcs_framer_ctrl

`default_nettype wire

// ---- rtl/rxcs_top.sv ----
// APB register bank holding the receive control-six register of two framers
//
// Operation
// - Bit 7 picks receive CRC6 variant: 0 standard, 1 Japanese.
// - Bit 6 picks latch source: 0 timed interval, 1 manual bit.
// - Manual update bit acts only while manual source is selected.
// - Manual bit rising: next cycle counts latched and running counters cleared.
// - Bits 4..0 choose receive channel copied into the monitor register.
// - Framer A copy at index 0x1E, framer B at 0xBE, independent.
`timescale 1ns/10ps
`default_nettype none

module rxcs_top #(
  parameter int SLOT_W = rxcs_pkg::SLOT_W
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rxcs_pkg::ADDR_W-1:0] paddr,
  input wire logic [rxcs_pkg::DATA_W-1:0] pwdata,
  output logic pready,
  output logic [rxcs_pkg::DATA_W-1:0] prdata,
  output logic pslverr,
  // Framer A receive side
  input wire logic timed_tick_a,
  input wire logic [rxcs_pkg::CHAN_W-1:0] rx_slot_num_a,
  input wire logic [SLOT_W-1:0] rx_slot_data_a,
  input wire logic rx_slot_valid_a,
  output logic rx_crc6_variant_select_a,
  output logic [rxcs_pkg::CHAN_W-1:0] rx_monitor_chan_a,
  output logic error_count_latch_a,
  // Framer B receive side
  input wire logic timed_tick_b,
  input wire logic [rxcs_pkg::CHAN_W-1:0] rx_slot_num_b,
  input wire logic [SLOT_W-1:0] rx_slot_data_b,
  input wire logic rx_slot_valid_b,
  output logic rx_crc6_variant_select_b,
  output logic [rxcs_pkg::CHAN_W-1:0] rx_monitor_chan_b,
  output logic error_count_latch_b
);

  // Decode
  wire setup_phase;
  wire access_phase;
  wire hit_ctrl_a;
  wire hit_ctrl_b;
  wire hit_mon_a;
  wire hit_mon_b;
  wire mapped;
  wire bad_access;
  wire wr_ctrl_a;
  wire wr_ctrl_b;
  wire [rxcs_pkg::REG_W-1:0] wbyte;
  wire [rxcs_pkg::REG_W-1:0] ctrl_a;
  wire [rxcs_pkg::REG_W-1:0] ctrl_b;
  wire [SLOT_W-1:0] rx_channel_monitor_reg_a;
  wire [SLOT_W-1:0] rx_channel_monitor_reg_b;
  wire [rxcs_pkg::DATA_W-1:0] rd_mux;
  wire [rxcs_pkg::DATA_W-1:0] prdata_next;
  wire pslverr_next;
  logic [rxcs_pkg::DATA_W-1:0] prdata_reg;
  logic pslverr_reg;

  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign hit_ctrl_a = (paddr == rxcs_pkg::byte_addr(rxcs_pkg::IDX_CTRL_A));
  assign hit_ctrl_b = (paddr == rxcs_pkg::byte_addr(rxcs_pkg::IDX_CTRL_B));
  assign hit_mon_a = (paddr == rxcs_pkg::byte_addr(rxcs_pkg::IDX_MON_A));
  assign hit_mon_b = (paddr == rxcs_pkg::byte_addr(rxcs_pkg::IDX_MON_B));
  assign mapped = hit_ctrl_a | hit_ctrl_b | hit_mon_a | hit_mon_b;
  // Monitor registers are read only; a write there is answered with an error
  assign bad_access = ~mapped | (pwrite & (hit_mon_a | hit_mon_b));
  assign wbyte = pwdata[rxcs_pkg::REG_W-1:0];
  // Writes land only at the completing edge of the access phase
  assign wr_ctrl_a = access_phase & pwrite & hit_ctrl_a;
  assign wr_ctrl_b = access_phase & pwrite & hit_ctrl_b;

  assign rd_mux = hit_ctrl_a ? {{rxcs_pkg::PAD_W{1'b0}}, ctrl_a} :
                  hit_ctrl_b ? {{rxcs_pkg::PAD_W{1'b0}}, ctrl_b} :
                  hit_mon_a ? {{(rxcs_pkg::DATA_W-SLOT_W){1'b0}}, rx_channel_monitor_reg_a} :
                  hit_mon_b ? {{(rxcs_pkg::DATA_W-SLOT_W){1'b0}}, rx_channel_monitor_reg_b} :
                  rxcs_pkg::RDATA_ZERO;

  // Read data captured in setup so the access phase needs no wait state
  assign prdata_next = setup_phase ? ((pwrite | bad_access) ? rxcs_pkg::RDATA_ZERO : rd_mux)
                                   : prdata_reg;
  assign pslverr_next = setup_phase ? bad_access : pslverr_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= rxcs_pkg::RDATA_ZERO;
      pslverr_reg <= 1'b0;
    end else begin
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign pready = access_phase;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & access_phase;

  // Framer A copy
  rxcs_framer_ctrl #(
    .SLOT_W(SLOT_W)
  ) u_framer_a (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_ctrl_a),
    .wdata(wbyte),
    .timed_tick(timed_tick_a),
    .slot_num(rx_slot_num_a),
    .slot_data(rx_slot_data_a),
    .slot_valid(rx_slot_valid_a),
    .ctrl_reg(ctrl_a),
    .crc6_sel(rx_crc6_variant_select_a),
    .chan_sel(rx_monitor_chan_a),
    .latch_reg(error_count_latch_a),
    .mon_reg(rx_channel_monitor_reg_a)
  );

  // Framer B copy
  rxcs_framer_ctrl #(
    .SLOT_W(SLOT_W)
  ) u_framer_b (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_ctrl_b),
    .wdata(wbyte),
    .timed_tick(timed_tick_b),
    .slot_num(rx_slot_num_b),
    .slot_data(rx_slot_data_b),
    .slot_valid(rx_slot_valid_b),
    .ctrl_reg(ctrl_b),
    .crc6_sel(rx_crc6_variant_select_b),
    .chan_sel(rx_monitor_chan_b),
    .latch_reg(error_count_latch_b),
    .mon_reg(rx_channel_monitor_reg_b)
  );

  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Latch must land within the software settle window
  localparam int SETTLE_CYC = rxcs_pkg::LATCH_SETTLE_CYC;

  sequence s_manual_rise_write_a;
    wr_ctrl_a && pwdata[rxcs_pkg::ACCUM_SRC_BIT] && pwdata[rxcs_pkg::MAN_LATCH_BIT]
      && !ctrl_a[rxcs_pkg::MAN_LATCH_BIT]
      && (ctrl_a[rxcs_pkg::ACCUM_SRC_BIT] || !timed_tick_a);
  endsequence

  sequence s_latch_once_a;
    !error_count_latch_a ##1 error_count_latch_a ##1 !error_count_latch_a;
  endsequence

  // A tick still counts in the write cycle if timed mode was active then
  sequence s_manual_rise_write_b;
    wr_ctrl_b && pwdata[rxcs_pkg::ACCUM_SRC_BIT] && pwdata[rxcs_pkg::MAN_LATCH_BIT]
      && !ctrl_b[rxcs_pkg::MAN_LATCH_BIT]
      && (ctrl_b[rxcs_pkg::ACCUM_SRC_BIT] || !timed_tick_b);
  endsequence

  sequence s_latch_once_b;
    !error_count_latch_b ##1 error_count_latch_b ##1 !error_count_latch_b;
  endsequence

  property p_crc6_follows_write;
    wr_ctrl_a |=> (rx_crc6_variant_select_a == $past(pwdata[rxcs_pkg::CRC6_SEL_BIT]));
  endproperty
  a_crc6_follows_write: assert property (p_crc6_follows_write)
    else $error("CRC6 variant select does not follow the written bit");

  property p_timed_source;
    !ctrl_a[rxcs_pkg::ACCUM_SRC_BIT] && !wr_ctrl_a
      |=> (error_count_latch_a == $past(timed_tick_a));
  endproperty
  a_timed_source: assert property (p_timed_source)
    else $error("Timed mode latch does not track the interval tick");

  property p_manual_ignored_in_timed;
    (!ctrl_b[rxcs_pkg::ACCUM_SRC_BIT] && !timed_tick_b) [*2] |=> !error_count_latch_b;
  endproperty
  a_manual_ignored_in_timed: assert property (p_manual_ignored_in_timed)
    else $error("Latch fired in timed mode without an interval tick");

  property p_manual_latch;
    s_manual_rise_write_a |=> s_latch_once_a;
  endproperty
  a_manual_latch: assert property (p_manual_latch)
    else $error("Manual rising edge did not give one latch pulse next cycle");

  property p_manual_latch_in_window;
    s_manual_rise_write_a |-> ##[1:SETTLE_CYC] error_count_latch_a;
  endproperty
  a_manual_latch_in_window: assert property (p_manual_latch_in_window)
    else $error("Manual latch later than the settle window");

  property p_monitor_capture;
    rx_slot_valid_b && (rx_slot_num_b == rx_monitor_chan_b)
      |=> (rx_channel_monitor_reg_b == $past(rx_slot_data_b));
  endproperty
  a_monitor_capture: assert property (p_monitor_capture)
    else $error("Monitor register missed the selected channel data");

  property p_monitor_hold;
    !(rx_slot_valid_a && (rx_slot_num_a == rx_monitor_chan_a)) |=> $stable(rx_channel_monitor_reg_a);
  endproperty
  a_monitor_hold: assert property (p_monitor_hold)
    else $error("Monitor register changed on an unselected channel");

  property p_copies_independent;
    wr_ctrl_a |=> $stable(ctrl_b);
  endproperty
  a_copies_independent: assert property (p_copies_independent)
    else $error("Write to framer A copy disturbed framer B copy");

  property p_edge_only;
    ctrl_a[rxcs_pkg::ACCUM_SRC_BIT] && $past(ctrl_a[rxcs_pkg::ACCUM_SRC_BIT])
      && error_count_latch_a |-> ##1 !error_count_latch_a;
  endproperty
  a_edge_only: assert property (p_edge_only)
    else $error("Manual bit held high gave more than one latch");

  property p_read_ctrl;
    setup_phase && !pwrite && hit_ctrl_b
      |=> (prdata[rxcs_pkg::REG_W-1:0] == $past(ctrl_b)) && pready;
  endproperty
  a_read_ctrl: assert property (p_read_ctrl)
    else $error("Read of framer B copy returned the wrong value");

  property p_manual_ignored_a;
    !ctrl_a[rxcs_pkg::ACCUM_SRC_BIT] && !timed_tick_a |=> !error_count_latch_a;
  endproperty
  a_manual_ignored_a: assert property (p_manual_ignored_a)
    else $error("Framer A latched in timed mode without an interval tick");

  property p_manual_latch_b;
    s_manual_rise_write_b |=> s_latch_once_b;
  endproperty
  a_manual_latch_b: assert property (p_manual_latch_b)
    else $error("Framer B manual rising edge did not give one latch pulse");

  property p_timed_source_b;
    !ctrl_b[rxcs_pkg::ACCUM_SRC_BIT] |=> (error_count_latch_b == $past(timed_tick_b));
  endproperty
  a_timed_source_b: assert property (p_timed_source_b)
    else $error("Framer B timed latch does not track the interval tick");

  property p_edge_only_b;
    ctrl_b[rxcs_pkg::ACCUM_SRC_BIT] && $past(ctrl_b[rxcs_pkg::ACCUM_SRC_BIT])
      && error_count_latch_b |-> ##1 !error_count_latch_b;
  endproperty
  a_edge_only_b: assert property (p_edge_only_b)
    else $error("Framer B manual bit held high gave more than one latch");

  property p_crc6_follows_write_b;
    wr_ctrl_b |=> (rx_crc6_variant_select_b == $past(pwdata[rxcs_pkg::CRC6_SEL_BIT]));
  endproperty
  a_crc6_follows_write_b: assert property (p_crc6_follows_write_b)
    else $error("Framer B CRC6 variant select does not follow the written bit");

  property p_chan_follows_write;
    wr_ctrl_a
      |=> (rx_monitor_chan_a == $past(pwdata[rxcs_pkg::CHAN_MSB:rxcs_pkg::CHAN_LSB]));
  endproperty
  a_chan_follows_write: assert property (p_chan_follows_write)
    else $error("Monitor channel select does not follow the written field");

  property p_write_lands_b;
    wr_ctrl_b |=> (ctrl_b == $past(wbyte));
  endproperty
  a_write_lands_b: assert property (p_write_lands_b)
    else $error("Write to framer B copy did not land");

  property p_monitor_hold_b;
    !(rx_slot_valid_b && (rx_slot_num_b == rx_monitor_chan_b))
      |=> $stable(rx_channel_monitor_reg_b);
  endproperty
  a_monitor_hold_b: assert property (p_monitor_hold_b)
    else $error("Framer B monitor register changed on an unselected channel");

  property p_read_monitor_a;
    setup_phase && !pwrite && hit_mon_a
      |=> (prdata[SLOT_W-1:0] == $past(rx_channel_monitor_reg_a));
  endproperty
  a_read_monitor_a: assert property (p_read_monitor_a)
    else $error("Read of framer A monitor register returned the wrong value");

  property p_monitor_write_refused;
    access_phase && pwrite && (hit_mon_a || hit_mon_b) |-> pslverr;
  endproperty
  a_monitor_write_refused: assert property (p_monitor_write_refused)
    else $error("Write to a monitor register was not refused");

  property p_unmapped_refused;
    access_phase && !mapped |-> pslverr && (prdata == rxcs_pkg::RDATA_ZERO);
  endproperty
  a_unmapped_refused: assert property (p_unmapped_refused)
    else $error("Unmapped access was not refused with zero data");

  property p_read_no_effect;
    access_phase && !pwrite |=> $stable(ctrl_a) && $stable(ctrl_b);
  endproperty
  a_read_no_effect: assert property (p_read_no_effect)
    else $error("A read changed a control register");

endmodule : rxcs_top

`default_nettype wire

// ---- tb/rx_framer_control_six_bench.sv ----
// Self-checking bench for the two-framer receive control register bank
`timescale 1ns/10ps
`default_nettype none

module rx_framer_control_six_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, s, acc;
  logic er, tk_a, tk_b, sv_a, sv_b, crc_a, crc_b, lat_a, lat_b;
  logic [4:0] sn_a, sn_b, ch_a, ch_b;
  logic [7:0] sd_a, sd_b, va, vb, d;
  int n_mismatch, checks_done, cyc, la_n, lb_n, la_c, n0, nb;

  rxcs_top u_rxcs_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .timed_tick_a(tk_a), .rx_slot_num_a(sn_a), .rx_slot_data_a(sd_a),
    .rx_slot_valid_a(sv_a), .rx_crc6_variant_select_a(crc_a), .rx_monitor_chan_a(ch_a),
    .error_count_latch_a(lat_a), .timed_tick_b(tk_b), .rx_slot_num_b(sn_b),
    .rx_slot_data_b(sd_b), .rx_slot_valid_b(sv_b), .rx_crc6_variant_select_b(crc_b),
    .rx_monitor_chan_b(ch_b), .error_count_latch_b(lat_b));

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    lfsr = v[0] ? ((v >> 1) ^ 32'h8020_0003) : (v >> 1);
  endfunction : lfsr

  // Own address arithmetic, independent of the design's helper
  function automatic logic [11:0] ad(input logic [9:0] idx);
    ad = {idx, 2'b00};
  endfunction : ad

  task automatic print_verdict;
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; er = pslverr; acc = cyc;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    chk("prdata", rd, e);
    chk("pslverr", {31'h0, er}, {31'h0, ee});
  endtask : rdchk

  task automatic slot(input logic fb, input logic [4:0] n, input logic [7:0] v);
    @(posedge pclk);
    if (fb) begin sv_b <= 1'b1; sn_b <= n; sd_b <= v; end
    else begin sv_a <= 1'b1; sn_a <= n; sd_a <= v; end
    @(posedge pclk);
    sv_a <= 1'b0; sv_b <= 1'b0; sn_a <= ~n; sd_a <= ~v; sn_b <= ~n; sd_b <= ~v;
  endtask : slot

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Latch pulse counting and the run ceiling
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (lat_a === 1'b1) begin la_n <= la_n + 1; la_c <= cyc; end
    if (lat_b === 1'b1) lb_n <= lb_n + 1;
    if (cyc == 5000) begin n_mismatch++; print_verdict(); end
  end

  initial begin
    {psel, penable, pwrite, tk_a, tk_b, sv_a, sv_b} = '0;
    {paddr, pwdata, sn_a, sn_b, sd_a, sd_b} = '0;
    {n_mismatch, checks_done, cyc, la_n, lb_n, la_c} = '0;
    s = 32'h0000_A95A; presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0000, 1'b0);
    rdchk(ad(rxcs_pkg::IDX_CTRL_B), 32'h0000_0000, 1'b0);
    rdchk(ad(rxcs_pkg::IDX_MON_A), 32'h0000_0000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      s = lfsr(s);
      va = (i == 0) ? 8'h9F : s[7:0] & 8'h9F;
      vb = (i == 1) ? 8'h9F : s[15:8] & 8'h9F;
      apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), {s[31:8], va});
      apb(1'b1, ad(rxcs_pkg::IDX_CTRL_B), {s[23:0], vb});
      rdchk(ad(rxcs_pkg::IDX_CTRL_A), {24'h0, va}, 1'b0);
      rdchk(ad(rxcs_pkg::IDX_CTRL_B), {24'h0, vb}, 1'b0);
      chk("crc_a", {31'h0, crc_a}, {31'h0, va[7]});
      chk("crc_b", {31'h0, crc_b}, {31'h0, vb[7]});
      chk("chan_a", {27'h0, ch_a}, {27'h0, va[4:0]});
      chk("chan_b", {27'h0, ch_b}, {27'h0, vb[4:0]});
    end
    n0 = lb_n;
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0040);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0060);
    repeat (3) @(posedge pclk);
    chk("latch_cycle", la_c, acc + 2);
    chk("latch_count", la_n, 1);
    // Held high, rewritten, and timed strobes must all be ignored
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0060);
    tk_a <= 1'b1;
    @(posedge pclk);
    tk_a <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("latch_count", la_n, 1);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0040);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0060);
    repeat (rxcs_pkg::LATCH_SETTLE_CYC) @(posedge pclk);
    chk("latch_count", la_n, 2);
    chk("latch_b_count", lb_n, n0);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0000);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0020);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0060);
    repeat (3) @(posedge pclk);
    chk("latch_count", la_n, 2);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0000);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_B), 32'h0000_0000);
    tk_a <= 1'b1;
    nb = lb_n;
    n0 = cyc;
    @(posedge pclk);
    tk_a <= 1'b0;
    tk_b <= 1'b1;
    @(posedge pclk);
    tk_b <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("timed_cycle", la_c, n0 + 2);
    chk("latch_b_count", lb_n, nb + 1);
    nb = lb_n;
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_B), 32'h0000_0040);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_B), 32'h0000_0060);
    repeat (3) @(posedge pclk);
    chk("latch_b_manual", lb_n, nb + 1);
    chk("latch_count", la_n, 3);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0005);
    apb(1'b1, ad(rxcs_pkg::IDX_CTRL_B), 32'h0000_0009);
    s = lfsr(s);
    d = s[7:0];
    slot(1'b0, 5'h05, d);
    slot(1'b1, 5'h05, ~d);
    slot(1'b0, 5'h04, ~d);
    rdchk(ad(rxcs_pkg::IDX_MON_A), {24'h0, d}, 1'b0);
    rdchk(ad(rxcs_pkg::IDX_MON_B), 32'h0000_0000, 1'b0);
    slot(1'b1, 5'h09, s[15:8]);
    rdchk(ad(rxcs_pkg::IDX_MON_B), {24'h0, s[15:8]}, 1'b0);
    apb(1'b1, ad(rxcs_pkg::IDX_MON_A), 32'h0000_00FF);
    chk("mon_write_err", {31'h0, er}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_00FF);
    chk("unmapped_err", {31'h0, er}, 32'h0000_0001);
    rdchk(12'h07C, 32'h0000_0000, 1'b1);
    rdchk(ad(rxcs_pkg::IDX_MON_A), {24'h0, d}, 1'b0);
    rdchk(ad(rxcs_pkg::IDX_CTRL_A), 32'h0000_0005, 1'b0);
    print_verdict();
  end
endmodule : rx_framer_control_six_bench

`default_nettype wire
